// file: bench/swr_pin_model.sv
`timescale 1ns/10ps
// ****************************************************
// port pins seen as wake sources
// ****************************************************
module swr_pin_model (
  input wire logic clk_sys,
  input wire logic [23:0] want,
  input wire logic [3:0] lag,
  output logic [23:0] pins
);
  logic [23:0] held = 24'h000000;
  logic [3:0] cnt = 4'h0;
  logic [23:0] shown = 24'h000000;
  assign pins = shown;
  // slow sources: a new level reaches the pins only after lag cycles
  always @(posedge clk_sys) begin
    if (want !== held) begin
      held <= want;
      cnt <= lag;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else begin
      shown <= held;
    end
  end
endmodule

// file: bench/testbench.sv
`timescale 1ns/10ps
module testbench;
  localparam int P = 20;
  logic clk_sys, rst_b, por_b, stop_enter, cpu_run, recovery_reset;
  logic sys_tick, timer_tick_clock, irq;
  logic [3:0] bus_bank, lag;
  logic [7:0] bus_rdata, rd;
  logic [23:0] want, pins;
  swr_pkg::swr_bus_req_t bus_req;
  integer seed = 22, mismatches = 0, n_tests = 0;
  integer i, code, lvl, dly, d, n0, n1;
  logic [7:0] st, mk;
  swr_stop_wake #(.POR_CYCLES(P)) u_swr_stop_wake (.clk_sys(clk_sys),
    .rst_b(rst_b), .por_b(por_b), .bus_bank(bus_bank), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .stop_enter(stop_enter), .pin_p0(pins[23:16]),
    .pin_p2(pins[15:8]), .pin_p3(pins[7:0]), .cpu_run(cpu_run),
    .recovery_reset(recovery_reset), .sys_tick(sys_tick),
    .timer_tick_clock(timer_tick_clock), .irq(irq));
  swr_pin_model u_swr_pin_model (.clk_sys(clk_sys), .want(want), .lag(lag),
    .pins(pins));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // ****************************************************
  // compare, bus and stimulus tasks
  // ****************************************************
  task check_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task check_bit(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task bus(input logic [7:0] a, input logic [7:0] dt, input logic w);
    @(posedge clk_sys) bus_req <= '{a, dt, w, !w};
    @(posedge clk_sys) bus_req <= '0;
    #1 rd = bus_rdata;
  endtask
  function automatic logic gate(integer c, logic [23:0] p);
    logic [7:0] p0, p2, p3;
    {p0, p2, p3} = p;
    case (c)
      1: gate = ~&p2[3:0];
      2: gate = ~&p2;
      3: gate = ~|p3[3:1];
      4: gate = ~&p3[3:1];
      5: gate = ~|{p3[3:1], p0[7], p0[0]};
      6: gate = ~&{p3[3:1], p0[7], p0[0]};
      default: gate = ~&{p3[3:1], p2[2:0]};
    endcase
  endfunction
  // biased tries so that all-high and all-low patterns turn up quickly
  task pick(input logic w);
    integer t;
    logic [23:0] p;
    for (t = 0; t < 4000; t++) begin
      p = 24'($random(seed));
      if (t % 3 == 1) p = p | 24'($random(seed)) | 24'($random(seed));
      if (t % 3 == 2) p = p & 24'($random(seed)) & 24'($random(seed));
      if ((gate(code, p) == lvl[0]) == w) break;
    end
    @(posedge clk_sys) want <= p;
    lag <= 4'($random(seed));
  endtask
  task stop;
    @(posedge clk_sys) stop_enter <= 1'b1;
    @(posedge clk_sys) stop_enter <= 1'b0;
    #1 check_bit("cpu_run", 1'b0, cpu_run);
  endtask
  initial begin
    #300000;
    mismatches++;
    give_verdict;
  end
  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    {rst_b, por_b, stop_enter, want, lag, bus_req} = '0;
    bus_bank = swr_pkg::BANK_F;
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    por_b <= 1'b1;
    bus(8'h0B, 8'h80, 1'b1);
    bus(8'h0B, 8'h00, 1'b0);
    check_byte("flag", 8'h00, rd);
    bus(8'h33, 8'h00, 1'b0);
    check_byte("unmapped", 8'h00, rd);
    for (i = 2; i >= 0; i--) begin
      // first pass writes the divider from a wrong bank; it must not land
      @(posedge clk_sys) bus_bank <= (i == 2) ? 4'h0 : swr_pkg::BANK_F;
      bus(8'h0B, 8'(8'h20 | (i != 0)), 1'b1);
      repeat (32) @(posedge clk_sys);
      n0 = 0;
      n1 = 0;
      repeat (64) begin
        @(posedge clk_sys) #1;
        n0 += sys_tick;
        n1 += timer_tick_clock;
      end
      check_byte("sys_tick", i == 1 ? 8'h04 : 8'h40, 8'(n0));
      check_byte("timer_tick", i == 1 ? 8'h04 : 8'h40, 8'(n1));
    end
    for (i = 0; i < 14; i++) begin
      code = i / 2 + 1;
      lvl = $random(seed) & 1;
      // bench clock stands for an oscillator, so delay off is legal
      dly = $random(seed) & 1;
      mk = (i % 3) ? 8'h03 : 8'h00;
      bus(swr_pkg::ADDR_IRQ_MASK, mk, 1'b1);
      // reserved bits of the second register always written as zero
      bus(8'h0D, (i % 2) ? 8'(lvl * 64 + code * 4) : 8'h00, 1'b1);
      bus(8'h0B, (i % 2) ? 8'(dly * 32) : 8'(lvl * 64 + dly * 32 + code * 4),
        1'b1);
      pick(1'b0);
      repeat (20) @(posedge clk_sys);
      stop();
      repeat (4) @(posedge clk_sys);
      #1 check_bit("stay_stopped", 1'b0, cpu_run);
      pick(1'b1);
      d = 0;
      repeat (60) begin
        @(posedge clk_sys) #1;
        if (recovery_reset === 1'b1) d++;
        if (cpu_run === 1'b1) break;
      end
      check_bit("woke", 1'b1, cpu_run);
      check_byte("delay", 8'(dly ? P : 0), 8'(d));
      st = 8'(1 + 2 * dly);
      check_bit("irq", |(st & mk), irq);
      bus(swr_pkg::ADDR_IRQ_STATUS, 8'h00, 1'b0);
      check_byte("status", st, rd);
      @(posedge clk_sys) #1 check_bit("irq_clear", 1'b0, irq);
      bus(8'h0B, 8'h00, 1'b0);
      check_byte("flag", 8'h80, rd);
      bus(8'h0D, 8'h00, 1'b0);
      check_byte("second_wo", 8'h00, rd);
    end
    @(posedge clk_sys) rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    bus(8'h0B, 8'h00, 1'b0);
    check_byte("flag_kept", 8'h80, rd);
    bus(8'h0B, 8'h20, 1'b1);
    stop();
    repeat (30) @(posedge clk_sys) want <= 24'($random(seed));
    #1 check_bit("por_only", 1'b0, cpu_run);
    @(posedge clk_sys) {rst_b, por_b} <= 2'b00;
    repeat (2) @(posedge clk_sys);
    {rst_b, por_b} <= 2'b11;
    bus(8'h0B, 8'h00, 1'b0);
    check_byte("flag_por", 8'h00, rd);
    give_verdict;
  end
endmodule

// file: core/swr_pkg.sv
package swr_pkg;

  // ****************************************************
  // register map
  // ****************************************************
  localparam logic [7:0] ADDR_CONFIG = 8'h0B;
  localparam logic [7:0] ADDR_CONFIG_SECOND = 8'h0D;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0E;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0F;
  localparam logic [3:0] BANK_F = 4'hF;

  // ****************************************************
  // field positions
  // ****************************************************
  localparam int POS_DIV16 = 0;
  localparam int POS_SRC_LO = 2;
  localparam int POS_DELAY = 5;
  localparam int POS_LEVEL = 6;
  localparam int POS_FLAG = 7;

  // ****************************************************
  // reset values
  // ****************************************************
  localparam logic [2:0] RST_SRC = 3'h0;
  localparam logic RST_LEVEL = 1'b0;
  localparam logic RST_DELAY = 1'b1;
  localparam logic RST_DIV16 = 1'b0;
  localparam logic [1:0] RST_MASK = 2'h0;

  // ****************************************************
  // timing
  // ****************************************************
  localparam int CLK_MHZ = 200;
  localparam int POR_INTERVAL_US = 5000;
  localparam int POR_CYCLES = POR_INTERVAL_US * CLK_MHZ;
  localparam int DIV_RATIO = 16;

  typedef struct packed {
    logic [2:0] src;
    logic level;
  } swr_src_cfg_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } swr_bus_req_t;

  typedef enum logic [1:0] {
    SWR_RUN = 2'b00,
    SWR_STOP = 2'b01,
    SWR_DELAY = 2'b10
  } swr_state_t;

endpackage

// file: core/swr_stop_wake.sv
`timescale 1ns/10ps
// Overview of operation
// - recovery flag set on wake, cleared by power-on
// - config bits write-only, flag read-only
// - bit 6 picks required wake level
// - bit 5 enables reset delay after wake
// - bits 4..2 pick primary wake source
// - bit 0 divides system/timer clocks by 16
// - primary config at bank F address 0B
// - codes 000 por, 001/010 port 2 nand
// - codes 011..111 port 3/0/2 nand/nor terms
// - second level bit, 0 low, 1 high
// - either selected source wakes the part
// - second config at bank F address 0D
// - second config resets, not on wake
// - no delay resumes at once, else por wait
module swr_stop_wake #(
  parameter int POR_CYCLES = swr_pkg::POR_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic por_b,
  input wire logic [3:0] bus_bank,
  input wire swr_pkg::swr_bus_req_t bus_req,
  output logic [7:0] bus_rdata,
  input wire logic stop_enter,
  input wire logic [7:0] pin_p0,
  input wire logic [7:0] pin_p2,
  input wire logic [7:0] pin_p3,
  output logic cpu_run,
  output logic recovery_reset,
  output logic sys_tick,
  output logic timer_tick_clock,
  output logic irq
);

  // ****************************************************
  // pin synchronisers
  // ****************************************************
  logic [23:0] pin_meta, next_pin_meta;
  logic [23:0] pin_sync, next_pin_sync;
  always_comb begin
    next_pin_meta = {pin_p3, pin_p2, pin_p0};
    next_pin_sync = pin_meta;
  end
  always_ff @(posedge clk_sys) begin
    pin_meta <= next_pin_meta;
    pin_sync <= next_pin_sync;
  end
  logic [7:0] p0;
  logic [7:0] p2;
  logic [7:0] p3;
  assign p0 = pin_sync[7:0];
  assign p2 = pin_sync[15:8];
  assign p3 = pin_sync[23:16];

  // ****************************************************
  // configuration registers
  // ****************************************************
  swr_pkg::swr_src_cfg_t cfg1, next_cfg1, cfg2, next_cfg2;
  logic delay_en, next_delay_en;
  logic div16, next_div16;
  logic [1:0] mask, next_mask;
  logic wr_cfg1;
  logic wr_cfg2;
  logic in_bank;

  assign in_bank = bus_bank == swr_pkg::BANK_F;
  assign wr_cfg1 = bus_req.wr && in_bank &&
                   bus_req.addr == swr_pkg::ADDR_CONFIG;
  assign wr_cfg2 = bus_req.wr && in_bank &&
                   bus_req.addr == swr_pkg::ADDR_CONFIG_SECOND;

  always_comb begin
    next_cfg1 = cfg1;
    next_cfg2 = cfg2;
    next_delay_en = delay_en;
    next_div16 = div16;
    next_mask = mask;
    if (wr_cfg1) begin
      next_cfg1.src = bus_req.wdata[swr_pkg::POS_SRC_LO +: 3];
      next_cfg1.level = bus_req.wdata[swr_pkg::POS_LEVEL];
      next_delay_en = bus_req.wdata[swr_pkg::POS_DELAY];
      next_div16 = bus_req.wdata[swr_pkg::POS_DIV16];
    end
    // reserved bits are ignored; software keeps them zero
    if (wr_cfg2) begin
      next_cfg2.src = bus_req.wdata[swr_pkg::POS_SRC_LO +: 3];
      next_cfg2.level = bus_req.wdata[swr_pkg::POS_LEVEL];
    end
    if (bus_req.wr && bus_req.addr == swr_pkg::ADDR_IRQ_MASK) begin
      next_mask = bus_req.wdata[1:0];
    end
  end

  // only rst_b reloads defaults; a wake never touches these
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cfg1 <= '{src: swr_pkg::RST_SRC, level: swr_pkg::RST_LEVEL};
      cfg2 <= '{src: swr_pkg::RST_SRC, level: swr_pkg::RST_LEVEL};
      delay_en <= swr_pkg::RST_DELAY;
      div16 <= swr_pkg::RST_DIV16;
      mask <= swr_pkg::RST_MASK;
    end else begin
      cfg1 <= next_cfg1;
      cfg2 <= next_cfg2;
      delay_en <= next_delay_en;
      div16 <= next_div16;
      mask <= next_mask;
    end
  end

  // ****************************************************
  // wake source gates
  // ****************************************************
  function automatic logic src_gate(input logic [2:0] code,
                                    input logic [7:0] a0,
                                    input logic [7:0] a2,
                                    input logic [7:0] a3);
    logic [4:0] mix;
    mix = {a3[3:1], a0[7], a0[0]};
    unique case (code)
      3'h0: src_gate = 1'b0;
      3'h1: src_gate = ~&a2[3:0];
      3'h2: src_gate = ~&a2;
      3'h3: src_gate = ~|a3[3:1];
      3'h4: src_gate = ~&a3[3:1];
      3'h5: src_gate = ~|mix;
      3'h6: src_gate = ~&mix;
      3'h7: src_gate = ~&{a3[3:1], a2[2:0]};
    endcase
  endfunction

  logic hit1;
  logic hit2;
  logic wake_hit;
  // level 0 needs a low gate output, level 1 a high one
  assign hit1 = (cfg1.src != 3'h0) &&
                !(src_gate(cfg1.src, p0, p2, p3) ^ cfg1.level);
  assign hit2 = (cfg2.src != 3'h0) &&
                !(src_gate(cfg2.src, p0, p2, p3) ^ cfg2.level);
  assign wake_hit = hit1 || hit2;

  // ****************************************************
  // stop sequencer
  // ****************************************************
  localparam int CW = $clog2(POR_CYCLES + 1);
  swr_pkg::swr_state_t state, next_state;
  logic [CW-1:0] dly, next_dly;
  logic flag, next_flag;
  logic wake_evt;

  assign wake_evt = state == swr_pkg::SWR_STOP && wake_hit;

  always_comb begin
    next_state = state;
    next_dly = dly;
    unique case (state)
      swr_pkg::SWR_RUN: begin
        if (stop_enter) begin
          next_state = swr_pkg::SWR_STOP;
        end
      end
      swr_pkg::SWR_STOP: begin
        if (wake_hit) begin
          if (delay_en) begin
            next_state = swr_pkg::SWR_DELAY;
            next_dly = CW'(POR_CYCLES - 1);
          end else begin
            next_state = swr_pkg::SWR_RUN;
          end
        end
      end
      swr_pkg::SWR_DELAY: begin
        if (dly == '0) begin
          next_state = swr_pkg::SWR_RUN;
        end else begin
          next_dly = dly - CW'(1);
        end
      end
      default: next_state = swr_pkg::SWR_RUN;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state <= swr_pkg::SWR_RUN;
      dly <= '0;
    end else begin
      state <= next_state;
      dly <= next_dly;
    end
  end

  // flag survives rst_b; only por_b clears it
  always_comb begin
    next_flag = flag || wake_evt;
  end
  always_ff @(posedge clk_sys) begin
    if (!por_b) begin
      flag <= 1'b0;
    end else begin
      flag <= next_flag;
    end
  end

  assign cpu_run = state == swr_pkg::SWR_RUN;
  assign recovery_reset = state == swr_pkg::SWR_DELAY;

  // ****************************************************
  // clock divider
  // ****************************************************
  // the ratio is only switched at a period boundary so a tick is
  // never shortened
  logic [3:0] div_cnt, next_div_cnt;
  logic div_act, next_div_act;
  logic tick, next_tick;
  logic div_wrap;

  assign div_wrap = !div_act || div_cnt == 4'(swr_pkg::DIV_RATIO - 1);
  always_comb begin
    next_div_cnt = div_wrap ? 4'h0 : div_cnt + 4'h1;
    next_div_act = div_wrap ? div16 : div_act;
    next_tick = div_wrap;
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      div_cnt <= 4'h0;
      div_act <= swr_pkg::RST_DIV16;
      tick <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      div_act <= next_div_act;
      tick <= next_tick;
    end
  end
  assign sys_tick = tick;
  assign timer_tick_clock = tick;

  // ****************************************************
  // interrupt status and read port
  // ****************************************************
  logic [1:0] irq_st, next_irq_st;
  logic [7:0] rdata, next_rdata;
  logic rd_st;

  assign rd_st = bus_req.rd && bus_req.addr == swr_pkg::ADDR_IRQ_STATUS;
  always_comb begin
    next_irq_st = rd_st ? 2'h0 : irq_st;
    next_irq_st = next_irq_st | {state == swr_pkg::SWR_DELAY &&
                                 next_state == swr_pkg::SWR_RUN,
                                 wake_evt};
    next_rdata = 8'h00;
    if (bus_req.rd) begin
      if (in_bank && bus_req.addr == swr_pkg::ADDR_CONFIG) begin
        next_rdata[swr_pkg::POS_FLAG] = flag;
      end else if (bus_req.addr == swr_pkg::ADDR_IRQ_STATUS) begin
        next_rdata = {6'h00, irq_st};
      end else if (bus_req.addr == swr_pkg::ADDR_IRQ_MASK) begin
        next_rdata = {6'h00, mask};
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      irq_st <= 2'h0;
      rdata <= 8'h00;
    end else begin
      irq_st <= next_irq_st;
      rdata <= next_rdata;
    end
  end
  assign bus_rdata = rdata;
  assign irq = |(irq_st & mask);

  // ****************************************************
  // checks
  // ****************************************************
  // wake with the delay selected, then the held reset phase
  sequence s_delay_wake;
    wake_evt && delay_en;
  endsequence
  sequence s_reset_held;
    recovery_reset[*8];
  endsequence

  a_flag_sets: assert property (@(posedge clk_sys)
    disable iff (!por_b) wake_evt |=> flag)
    else $error("flag not set on wake");
  a_flag_holds: assert property (@(posedge clk_sys)
    disable iff (!por_b) flag |=> flag)
    else $error("flag lost without power-on");
  a_flag_por: assert property (@(posedge clk_sys)
    !por_b |=> !flag)
    else $error("flag kept over power-on");
  a_cfg_write_only: assert property (@(posedge clk_sys)
    disable iff (!rst_b) (bus_req.rd && in_bank &&
    bus_req.addr == swr_pkg::ADDR_CONFIG) |=> bus_rdata[6:0] == 7'h00)
    else $error("config reads back");
  a_src1_decode: assert property (@(posedge clk_sys)
    disable iff (!rst_b) wr_cfg1 |=> cfg1.src == $past(bus_req.wdata[4:2]))
    else $error("source field wrong");
  a_src2_decode: assert property (@(posedge clk_sys)
    disable iff (!rst_b) wr_cfg2 |=> cfg2.level == $past(bus_req.wdata[6]))
    else $error("level bit wrong");
  a_bank_decode: assert property (@(posedge clk_sys)
    disable iff (!rst_b) (bus_req.wr && bus_bank != swr_pkg::BANK_F)
    |=> $stable({cfg1, delay_en, div16})) else $error("wrong bank wrote");
  a_cfg2_kept: assert property (@(posedge clk_sys)
    disable iff (!rst_b) !wr_cfg2 |=> $stable(cfg2))
    else $error("second config changed unwritten");
  a_only_in_stop: assert property (@(posedge clk_sys)
    disable iff (!rst_b) (state == swr_pkg::SWR_RUN && !stop_enter)
    |=> cpu_run) else $error("woke outside stop");
  a_stop_wait: assert property (@(posedge clk_sys)
    disable iff (!rst_b) (state == swr_pkg::SWR_STOP && !wake_hit)
    |=> !cpu_run) else $error("left stop without wake");
  a_no_delay: assert property (@(posedge clk_sys)
    disable iff (!rst_b) (wake_evt && !delay_en) |=> cpu_run)
    else $error("no-delay wake stalled");
  a_delay_held: assert property (@(posedge clk_sys)
    disable iff (!rst_b) s_delay_wake |=> s_reset_held)
    else $error("delay too short");
  a_delay_load: assert property (@(posedge clk_sys)
    disable iff (!rst_b) s_delay_wake |=> dly == CW'(POR_CYCLES - 1))
    else $error("delay count not loaded");
  a_delay_exit: assert property (@(posedge clk_sys)
    disable iff (!rst_b) (recovery_reset && dly == '0) |=> cpu_run)
    else $error("delay overran");
  a_por_wake: assert property (@(posedge clk_sys)
    disable iff (!rst_b) (cfg1.src == 3'h0 && cfg2.src == 3'h0)
    |-> !wake_hit) else $error("por-only code woke");
  a_div_tick: assert property (@(posedge clk_sys)
    disable iff (!rst_b) (div_act && tick && $past(div_act)) |=> !tick[*8])
    else $error("divided tick too short");
  a_div_pass: assert property (@(posedge clk_sys)
    disable iff (!rst_b) !div_act |=> tick)
    else $error("undivided tick missing");

endmodule
